// file: pkg/bctu_pkg.sv
// Purpose: constants for the bus compare trigger unit
// Assumes: 16-bit cpu address, 8-bit cpu data, 8-entry capture fifo
// Notes:   register indices are word offsets on the plain register port
package bctu_pkg;
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 8;
    localparam int          CNT_W      = 4;
    localparam int          PTR_W      = 3;
    localparam int          REG_AW     = 4;
    // register map (high register space)
    localparam logic [3:0]  REG_CMPA_HI = 4'h0;
    localparam logic [3:0]  REG_CMPA_LO = 4'h1;
    localparam logic [3:0]  REG_CMPB_HI = 4'h2;
    localparam logic [3:0]  REG_CMPB_LO = 4'h3;
    localparam logic [3:0]  REG_FIFO_HI = 4'h4;
    localparam logic [3:0]  REG_FIFO_LO = 4'h5;
    localparam logic [3:0]  REG_CTRL    = 4'h6;
    localparam logic [3:0]  REG_TRIG    = 4'h7;
    localparam logic [3:0]  REG_STAT    = 4'h8;
    // control register fields
    localparam int          CTL_ARM      = 7;
    localparam int          CTL_BRK_EN   = 6;
    localparam int          CTL_A_DIR_EN = 5;
    localparam int          CTL_A_DIR    = 4;
    localparam int          CTL_B_DIR_EN = 3;
    localparam int          CTL_B_DIR    = 2;
    localparam int          CTL_OPC_EN   = 1;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  TRIG_RST     = 8'h00;
    // trigger mode field, low four bits of trigger register
    localparam logic [3:0]  TM_A_ONLY     = 4'h0;
    localparam logic [3:0]  TM_A_OR_B     = 4'h1;
    localparam logic [3:0]  TM_A_THEN_B   = 4'h2;
    localparam logic [3:0]  TM_A_AND_BD   = 4'h3;
    localparam logic [3:0]  TM_A_AND_NBD  = 4'h4;
    localparam logic [3:0]  TM_INSIDE     = 4'h5;
    localparam logic [3:0]  TM_OUTSIDE    = 4'h6;
    // action field, bits 5:4 of trigger register
    localparam int          TRG_ACT_LSB   = 4;
    localparam logic [1:0]  ACT_BREAK     = 2'h0;
    localparam logic [1:0]  ACT_STORE     = 2'h1;
    localparam logic [1:0]  ACT_COF_BEGIN = 2'h2;
    localparam logic [1:0]  ACT_COF_END   = 2'h3;
endpackage

// file: logic/bctu_top.sv
// Purpose: bus compare trigger unit (on_chip_trace_unit)
// Assumes: cpu bus clock clk, one bus cycle per clk when cpu_cycle is high
// Notes:   reached by the background_debug_ctrl over a plain register port
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module bctu_top
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // cpu bus
    input  wire logic        cpu_cycle,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_rdata,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_rw,
    input  wire logic        cpu_opfetch,
    input  wire logic        cpu_opexec,
    input  wire logic [15:0] cpu_exec_addr,
    input  wire logic        cpu_cof,
    input  wire logic        bdc_access,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // breakpoint
    output logic             cpu_break
);
    default clocking dclk @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] cmpa_r;
    logic [15:0] cmpb_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  trig_r;
    logic [15:0] fifo_mem [bctu_pkg::FIFO_DEPTH];
    logic [2:0]  wr_ptr_r;
    logic [2:0]  rd_ptr_r;
    logic [3:0]  cnt_r;
    logic [7:0]  hold_lo_r;
    logic [15:0] opc_addr_r;
    logic        opc_pend_r;
    logic        hit_a_r;
    logic        hit_b_r;
    logic        hit_rng_r;
    logic        seen_a_r;
    logic        tracing_r;
    logic        done_r;
    logic [7:0]  bdata_r;

    logic [3:0]  mode;
    logic [1:0]  act;
    logic        data_mode;
    logic [7:0]  b_data;
    logic        a_dir_ok;
    logic        b_dir_ok;
    logic        eq_a;
    logic        eq_b;
    logic        in_rng;
    logic        a_opc;
    logic        b_opc;
    logic        fire;
    logic        push;
    logic [15:0] push_word;
    logic        pop;
    logic        armed;

    assign mode  = trig_r[3:0];
    assign act   = trig_r[bctu_pkg::TRG_ACT_LSB +: 2];
    assign armed = ctrl_r[bctu_pkg::CTL_ARM];
    assign data_mode = (mode == bctu_pkg::TM_A_AND_BD)
                    || (mode == bctu_pkg::TM_A_AND_NBD);

    // data bus pick for comparator B
    always_comb
    begin
        if (ctrl_r[bctu_pkg::CTL_A_DIR_EN] && !ctrl_r[bctu_pkg::CTL_A_DIR])
            b_data = cpu_wdata;
        else
            b_data = cpu_rdata;
    end

    // direction qualify, ignored when its enable is clear
    assign a_dir_ok = !ctrl_r[bctu_pkg::CTL_A_DIR_EN]
                   || (cpu_rw == ctrl_r[bctu_pkg::CTL_A_DIR]);
    assign b_dir_ok = !ctrl_r[bctu_pkg::CTL_B_DIR_EN]
                   || (cpu_rw == ctrl_r[bctu_pkg::CTL_B_DIR]);

    assign eq_a   = (cpu_addr == cmpa_r);
    assign eq_b   = data_mode ? (b_data == cmpb_r[7:0])
                              : (cpu_addr == cmpb_r);
    assign in_rng = (cpu_addr >= cmpa_r) && (cpu_addr <= cmpb_r);

    // opcode tracking: match taken at fetch, confirmed at execute
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            opc_pend_r <= 1'b0;
            opc_addr_r <= 16'h0000;
        end
        else if (cpu_opfetch && !bdc_access && (eq_a || eq_b))
        begin
            opc_pend_r <= 1'b1;
            opc_addr_r <= cpu_addr;
        end
        else if (cpu_opexec)
            opc_pend_r <= 1'b0;
    end

    assign a_opc = cpu_opexec && (cpu_exec_addr == cmpa_r)
                && (opc_addr_r == cmpa_r);
    assign b_opc = cpu_opexec && (cpu_exec_addr == cmpb_r)
                && (opc_addr_r == cmpb_r);

    // registered qualified hits
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hit_a_r   <= 1'b0;
            hit_b_r   <= 1'b0;
            hit_rng_r <= 1'b0;
            bdata_r   <= 8'h00;
        end
        else if (bdc_access || !cpu_cycle)
        begin
            hit_a_r   <= 1'b0;
            hit_b_r   <= 1'b0;
            hit_rng_r <= 1'b0;
        end
        else if (ctrl_r[bctu_pkg::CTL_OPC_EN])
        begin
            hit_a_r   <= a_opc && opc_pend_r;
            hit_b_r   <= b_opc && opc_pend_r;
            hit_rng_r <= 1'b0;
        end
        else
        begin
            hit_a_r   <= eq_a && a_dir_ok;
            hit_b_r   <= eq_b && b_dir_ok;
            hit_rng_r <= a_dir_ok && (in_rng
                         != (mode == bctu_pkg::TM_OUTSIDE));
            bdata_r   <= b_data;
        end
    end

    // trigger mode combination
    always_comb
    begin
        case (mode)
            bctu_pkg::TM_A_ONLY:    fire = hit_a_r;
            bctu_pkg::TM_A_OR_B:    fire = hit_a_r || hit_b_r;
            bctu_pkg::TM_A_THEN_B:  fire = seen_a_r && hit_b_r;
            bctu_pkg::TM_A_AND_BD:  fire = hit_a_r && hit_b_r;
            bctu_pkg::TM_A_AND_NBD: fire = hit_a_r && !hit_b_r;
            bctu_pkg::TM_INSIDE:    fire = hit_rng_r;
            bctu_pkg::TM_OUTSIDE:   fire = hit_rng_r;
            default:                fire = 1'b0;
        endcase
        fire = fire && armed && !done_r;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            seen_a_r <= 1'b0;
        else if (!armed)
            seen_a_r <= 1'b0;
        else if (hit_a_r)
            seen_a_r <= 1'b1;
    end

    // action on a qualified match
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tracing_r <= 1'b0;
            done_r    <= 1'b0;
            cpu_break <= 1'b0;
        end
        else
        begin
            cpu_break <= fire && (act == bctu_pkg::ACT_BREAK)
                      && ctrl_r[bctu_pkg::CTL_BRK_EN];
            if (!armed)
            begin
                tracing_r <= 1'b0;
                done_r    <= 1'b0;
            end
            else if (fire && act == bctu_pkg::ACT_COF_BEGIN)
                tracing_r <= 1'b1;
            else if (fire && act == bctu_pkg::ACT_COF_END)
                done_r    <= 1'b1;
            else if (tracing_r && cnt_r == 4'(bctu_pkg::FIFO_DEPTH))
                done_r    <= 1'b1;
        end
    end

    // fifo fill: data store or change-of-flow trace
    always_comb
    begin
        push      = 1'b0;
        push_word = 16'h0000;
        if (fire && act == bctu_pkg::ACT_STORE)
        begin
            push      = 1'b1;
            push_word = {8'h00, bdata_r};
        end
        else if (armed && !done_r && cpu_cof && !bdc_access
                 && ((act == bctu_pkg::ACT_COF_BEGIN && tracing_r
                      && cnt_r != 4'(bctu_pkg::FIFO_DEPTH))
                  || act == bctu_pkg::ACT_COF_END))
        begin
            push      = 1'b1;
            push_word = cpu_addr;
        end
    end

    // a read of the high byte pops a word; low byte held for next read
    assign pop = reg_rd && (reg_addr == bctu_pkg::REG_FIFO_HI)
              && (cnt_r != 4'h0);

    always_ff @(posedge clk)
    begin
        if (push)
            fifo_mem[wr_ptr_r] <= push_word;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_r <= 3'h0;
            rd_ptr_r <= 3'h0;
            cnt_r    <= 4'h0;
        end
        else if (reg_wr && reg_addr == bctu_pkg::REG_CTRL
                 && reg_wdata[bctu_pkg::CTL_ARM] && !armed)
        begin
            wr_ptr_r <= 3'h0;
            rd_ptr_r <= 3'h0;
            cnt_r    <= 4'h0;
        end
        else
        begin
            if (push)
            begin
                // full fifo overwrites oldest for store and trace-end actions
                wr_ptr_r <= wr_ptr_r + 3'h1;
                if (cnt_r == 4'(bctu_pkg::FIFO_DEPTH))
                    rd_ptr_r <= rd_ptr_r + 3'h1;
            end
            if (pop)
                rd_ptr_r <= rd_ptr_r + 3'h1;
            if (push && !pop && cnt_r != 4'(bctu_pkg::FIFO_DEPTH))
                cnt_r <= cnt_r + 4'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hold_lo_r <= 8'h00;
        else if (pop)
            hold_lo_r <= fifo_mem[rd_ptr_r][7:0];
    end

    // control registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cmpa_r <= 16'h0000;
            cmpb_r <= 16'h0000;
            ctrl_r <= bctu_pkg::CTRL_RST;
            trig_r <= bctu_pkg::TRIG_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                bctu_pkg::REG_CMPA_HI: cmpa_r[15:8] <= reg_wdata;
                bctu_pkg::REG_CMPA_LO: cmpa_r[7:0]  <= reg_wdata;
                bctu_pkg::REG_CMPB_HI: cmpb_r[15:8] <= reg_wdata;
                bctu_pkg::REG_CMPB_LO: cmpb_r[7:0]  <= reg_wdata;
                bctu_pkg::REG_CTRL:    ctrl_r       <= reg_wdata;
                bctu_pkg::REG_TRIG:    trig_r       <= reg_wdata;
                default:               ;
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                bctu_pkg::REG_CMPA_HI: reg_rdata <= cmpa_r[15:8];
                bctu_pkg::REG_CMPA_LO: reg_rdata <= cmpa_r[7:0];
                bctu_pkg::REG_CMPB_HI: reg_rdata <= cmpb_r[15:8];
                bctu_pkg::REG_CMPB_LO: reg_rdata <= cmpb_r[7:0];
                bctu_pkg::REG_FIFO_HI:
                    reg_rdata <= (cnt_r != 4'h0)
                               ? fifo_mem[rd_ptr_r][15:8] : 8'h00;
                bctu_pkg::REG_FIFO_LO: reg_rdata <= hold_lo_r;
                bctu_pkg::REG_CTRL:    reg_rdata <= ctrl_r;
                bctu_pkg::REG_TRIG:    reg_rdata <= trig_r;
                bctu_pkg::REG_STAT:
                    reg_rdata <= {tracing_r, done_r, 2'b00, cnt_r};
                default:               reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    a_fifo_count_max: assert property (
        cnt_r <= 4'(bctu_pkg::FIFO_DEPTH))
        else $error("fifo count above depth");
    a_bdc_no_hit: assert property (
        bdc_access |=> !hit_a_r && !hit_b_r && !hit_rng_r)
        else $error("hit during debug access");
    a_hit_a_cause: assert property (
        cpu_cycle && !bdc_access && !ctrl_r[bctu_pkg::CTL_OPC_EN]
        && !ctrl_r[bctu_pkg::CTL_A_DIR_EN] && cpu_addr == cmpa_r
        |=> hit_a_r)
        else $error("address match A missed");
    a_dir_ignored: assert property (
        hit_a_r && ctrl_r[bctu_pkg::CTL_A_DIR_EN]
        && !$past(ctrl_r[bctu_pkg::CTL_OPC_EN]) && $stable(ctrl_r)
        |-> $past(cpu_rw) == ctrl_r[bctu_pkg::CTL_A_DIR])
        else $error("A hit with wrong direction");
    a_break_cause: assert property (
        cpu_break |-> $past(fire) && $past(act) == bctu_pkg::ACT_BREAK)
        else $error("break without break trigger");
    a_push_count: assert property (
        push && !pop && cnt_r < 4'h8 && !reg_wr
        |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("fifo count did not follow push");
    a_stat_read: assert property (
        reg_rd && reg_addr == bctu_pkg::REG_STAT
        |=> reg_rdata[3:0] == $past(cnt_r))
        else $error("status count wrong");
    a_opc_no_fetch: assert property (
        ctrl_r[bctu_pkg::CTL_OPC_EN] && !cpu_opexec && !bdc_access
        |=> !hit_a_r)
        else $error("hit on prefetch only");
endmodule

// file: bench/bctu_cpu_model.sv
// Purpose: cpu bus and debug access side for the trigger unit
// Assumes: one bus cycle per call, driven just after a rising edge
// Notes:   released address, data and rw lines show the inverse of their last value; strobes go low
`timescale 1ns/100ps
module bctu_cpu_model
(
    // clock
    input  wire logic        clk,
    // cpu bus
    output logic             cpu_cycle,
    output logic [15:0]      cpu_addr,
    output logic [7:0]       cpu_rdata,
    output logic [7:0]       cpu_wdata,
    output logic             cpu_rw,
    output logic             cpu_opfetch,
    output logic             cpu_opexec,
    output logic [15:0]      cpu_exec_addr,
    output logic             cpu_cof,
    // debug access
    output logic             bdc_access
);
    initial
    begin
        cpu_cycle     = 1'b0;
        cpu_addr      = 16'hffff;
        cpu_rdata     = 8'hff;
        cpu_wdata     = 8'hff;
        cpu_rw        = 1'b1;
        cpu_opfetch   = 1'b0;
        cpu_opexec    = 1'b0;
        cpu_exec_addr = 16'hffff;
        cpu_cof       = 1'b0;
        bdc_access    = 1'b0;
    end

    // k: bit0 fetch, bit1 execute, bit2 change of flow, bit3 debug access
    task automatic cyc(input logic [15:0] a, input logic [7:0] rd,
                       input logic [7:0] wd, input logic rw,
                       input logic [3:0] k);
        @(posedge clk);
        cpu_cycle     <= 1'b1;
        cpu_addr      <= a;
        cpu_rdata     <= rd;
        cpu_wdata     <= wd;
        cpu_rw        <= rw;
        cpu_opfetch   <= k[0];
        cpu_opexec    <= k[1];
        cpu_exec_addr <= k[1] ? a : ~a;
        cpu_cof       <= k[2];
        bdc_access    <= k[3];
        @(posedge clk);
        cpu_cycle     <= 1'b0;
        cpu_addr      <= ~a;
        cpu_rdata     <= ~rd;
        cpu_wdata     <= ~wd;
        cpu_rw        <= ~rw;
        cpu_opfetch   <= 1'b0;
        cpu_opexec    <= 1'b0;
        cpu_exec_addr <= ~a;
        cpu_cof       <= 1'b0;
        bdc_access    <= 1'b0;
    endtask
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench for the bus compare trigger unit
// Assumes: 20 MHz clock, register reads answer one cycle later
// Notes:   cpu traffic comes from the partner model
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] C_ARM = 8'h01 << bctu_pkg::CTL_ARM;
    localparam logic [7:0] C_BRK = 8'h01 << bctu_pkg::CTL_BRK_EN;
    localparam logic [7:0] C_ADE = 8'h01 << bctu_pkg::CTL_A_DIR_EN;
    localparam logic [7:0] C_AD  = 8'h01 << bctu_pkg::CTL_A_DIR;
    localparam logic [7:0] C_OPC = 8'h01 << bctu_pkg::CTL_OPC_EN;
    localparam logic [7:0] C_BDE = 8'h01 << bctu_pkg::CTL_B_DIR_EN;
    logic        clk, reset, cpu_cycle, cpu_rw, cpu_opfetch, cpu_opexec;
    logic        cpu_cof, bdc_access, reg_wr, reg_rd, cpu_break;
    logic [15:0] cpu_addr, cpu_exec_addr;
    logic [7:0]  cpu_rdata, cpu_wdata, reg_wdata, reg_rdata, rv;
    logic [3:0]  reg_addr;
    int          n_fail, n_checks, n_brk, n_cyc;

    bctu_cpu_model cpu (.clk(clk), .cpu_cycle(cpu_cycle),
        .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
        .cpu_rw(cpu_rw), .cpu_opfetch(cpu_opfetch), .cpu_opexec(cpu_opexec),
        .cpu_exec_addr(cpu_exec_addr), .cpu_cof(cpu_cof),
        .bdc_access(bdc_access));
    bctu_top DUT (.clk(clk), .reset(reset), .cpu_cycle(cpu_cycle),
        .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
        .cpu_rw(cpu_rw), .cpu_opfetch(cpu_opfetch), .cpu_opexec(cpu_opexec),
        .cpu_exec_addr(cpu_exec_addr), .cpu_cof(cpu_cof),
        .bdc_access(bdc_access), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_break(cpu_break));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        n_cyc <= n_cyc + 1;
        if (cpu_break === 1'b1)
            n_brk <= n_brk + 1;
        if (n_cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk8(input string s, input logic [7:0] e,
                        input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask

    task automatic chk_n(input string s, input int e, input int g);
        n_checks++;
        if (g != e)
        begin
            $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                        input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata & m;
        chk8("register read", e, rv);
    endtask

    task automatic cfg(input logic [15:0] ca, input logic [15:0] cb,
                       input logic [1:0] act, input logic [3:0] md,
                       input logic [7:0] ctl);
        wr(bctu_pkg::REG_CMPA_HI, ca[15:8]);
        wr(bctu_pkg::REG_CMPA_LO, ca[7:0]);
        wr(bctu_pkg::REG_CMPB_HI, cb[15:8]);
        wr(bctu_pkg::REG_CMPB_LO, cb[7:0]);
        wr(bctu_pkg::REG_TRIG, {2'h0, act, md});
        wr(bctu_pkg::REG_CTRL, 8'h00);
        wr(bctu_pkg::REG_CTRL, ctl);
    endtask

    // one bus cycle, then count break pulses that follow
    task automatic hit(input logic [15:0] a, input logic rw,
                       input logic [3:0] k, input int e);
        int b;
        b = n_brk;
        cpu.cyc(a, 8'h5a, 8'h33, rw, k);
        repeat (4) @(posedge clk);
        chk_n("break count", e, n_brk - b);
    endtask

    task automatic t_regs();
        rchk(bctu_pkg::REG_CTRL, bctu_pkg::CTRL_RST, 8'hff);
        rchk(bctu_pkg::REG_TRIG, bctu_pkg::TRIG_RST, 8'hff);
        rchk(bctu_pkg::REG_STAT, 8'h00, 8'h0f);
        wr(bctu_pkg::REG_CMPA_HI, 8'hc3);
        rchk(bctu_pkg::REG_CMPA_HI, 8'hc3, 8'hff);
        rchk(4'hf, 8'h00, 8'hff);
    endtask

    task automatic t_break();
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_ONLY,
            C_ARM | C_BRK);
        hit(16'h1235, 1'b1, 4'h0, 0);
        hit(16'h1234, 1'b1, 4'h0, 1);
        hit(16'h1234, 1'b1, 4'h8, 0);
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_ONLY,
            C_ARM | C_BRK | C_ADE | C_AD);
        hit(16'h1234, 1'b0, 4'h0, 0);
        hit(16'h1234, 1'b1, 4'h0, 1);
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_ONLY,
            C_ARM | C_BRK | C_OPC);
        hit(16'h1234, 1'b1, 4'h1, 0);
        hit(16'h1234, 1'b1, 4'h2, 1);
    endtask

    task automatic t_range();
        cfg(16'h1000, 16'h2000, bctu_pkg::ACT_BREAK, bctu_pkg::TM_INSIDE,
            C_ARM | C_BRK);
        hit(16'h1800, 1'b1, 4'h0, 1);
        hit(16'h3000, 1'b1, 4'h0, 0);
        cfg(16'h1000, 16'h2000, bctu_pkg::ACT_BREAK, bctu_pkg::TM_OUTSIDE,
            C_ARM | C_BRK);
        hit(16'h3000, 1'b1, 4'h0, 1);
        hit(16'h1800, 1'b1, 4'h0, 0);
    endtask

    task automatic t_modes();
        cfg(16'h1234, 16'h4321, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_OR_B,
            C_ARM | C_BRK);
        hit(16'h4321, 1'b1, 4'h0, 1);
        cfg(16'h1234, 16'h4321, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_OR_B,
            C_ARM | C_BRK | C_BDE);
        hit(16'h4321, 1'b1, 4'h0, 0);
        hit(16'h4321, 1'b0, 4'h0, 1);
        cfg(16'h1234, 16'h4321, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_THEN_B,
            C_ARM | C_BRK);
        hit(16'h4321, 1'b1, 4'h0, 0);
        hit(16'h1234, 1'b1, 4'h0, 0);
        hit(16'h4321, 1'b1, 4'h0, 1);
        cfg(16'h1234, 16'h005a, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_AND_BD,
            C_ARM | C_BRK);
        hit(16'h1234, 1'b1, 4'h0, 1);
        cfg(16'h1234, 16'h0033, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_AND_BD,
            C_ARM | C_BRK);
        hit(16'h1234, 1'b0, 4'h0, 0);
        cfg(16'h1234, 16'h0033, bctu_pkg::ACT_BREAK, bctu_pkg::TM_A_AND_BD,
            C_ARM | C_BRK | C_ADE);
        hit(16'h1234, 1'b0, 4'h0, 1);
    endtask

    // read data equals comparator B, so only the write bus can miss it
    task automatic t_store();
        cfg(16'h1234, 16'h005a, bctu_pkg::ACT_STORE,
            bctu_pkg::TM_A_AND_NBD, C_ARM | C_ADE);
        for (int i = 1; i <= 3; i++)
            cpu.cyc(16'h1234, 8'h5a, 8'(i), 1'b0, 4'h0);
        repeat (3) @(posedge clk);
        rchk(bctu_pkg::REG_STAT, 8'h03, 8'h0f);
        for (int i = 1; i <= 3; i++)
        begin
            rchk(bctu_pkg::REG_FIFO_HI, 8'h00, 8'hff);
            rchk(bctu_pkg::REG_FIFO_LO, 8'(i), 8'hff);
        end
        rchk(bctu_pkg::REG_FIFO_HI, 8'h00, 8'hff);
        rchk(bctu_pkg::REG_STAT, 8'h00, 8'h0f);
    endtask

    task automatic t_trace();
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_COF_BEGIN,
            bctu_pkg::TM_A_ONLY, C_ARM);
        cpu.cyc(16'h0150, 8'h00, 8'h00, 1'b1, 4'h4);
        hit(16'h1234, 1'b1, 4'h0, 0);
        for (int i = 0; i < 10; i++)
            cpu.cyc(16'h0100 + 16'(i), 8'h00, 8'h00, 1'b1, 4'h4);
        repeat (3) @(posedge clk);
        rchk(bctu_pkg::REG_STAT, 8'h08, 8'h0f);
        for (int i = 0; i < 8; i++)
        begin
            rchk(bctu_pkg::REG_FIFO_HI, 8'h01, 8'hff);
            rchk(bctu_pkg::REG_FIFO_LO, 8'(i), 8'hff);
        end
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_COF_END,
            bctu_pkg::TM_A_ONLY, C_ARM);
        cpu.cyc(16'h0200, 8'h00, 8'h00, 1'b1, 4'h4);
        cpu.cyc(16'h0201, 8'h00, 8'h00, 1'b1, 4'h4);
        hit(16'h1234, 1'b1, 4'h0, 0);
        cpu.cyc(16'h0202, 8'h00, 8'h00, 1'b1, 4'h4);
        repeat (3) @(posedge clk);
        rchk(bctu_pkg::REG_STAT, 8'h02, 8'h0f);
        rchk(bctu_pkg::REG_FIFO_HI, 8'h02, 8'hff);
        rchk(bctu_pkg::REG_FIFO_LO, 8'h00, 8'hff);
        cfg(16'h1234, 16'h0000, bctu_pkg::ACT_COF_END,
            bctu_pkg::TM_A_ONLY, C_ARM);
        for (int i = 0; i < 10; i++)
            cpu.cyc(16'h0300 + 16'(i), 8'h00, 8'h00, 1'b1, 4'h4);
        hit(16'h1234, 1'b1, 4'h0, 0);
        rchk(bctu_pkg::REG_STAT, 8'h08, 8'h0f);
        rchk(bctu_pkg::REG_FIFO_HI, 8'h03, 8'hff);
        rchk(bctu_pkg::REG_FIFO_LO, 8'h02, 8'hff);
    endtask

    initial
    begin
        reset     = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        n_fail    = 0;
        n_checks  = 0;
        n_brk     = 0;
        n_cyc     = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_break();
        t_range();
        t_modes();
        t_store();
        t_trace();
        stop_test();
    end
endmodule
